// ### core/hcsc_consts.svh
// constants for the hub status/command register block
// assumes a configuration-space register port with byte address and write strobe
// Functional notes
// - status/command register at FFh, bits 2:0
// - sleep serial port after write acknowledge
// - sleep and attach bits write once
// - soft reset restores interface and memory
// - soft reset bit clears itself
// - attach low keeps serial slave, no connect
// - attach high signals upstream attach
// - attach protects 00h-FEh non-modify writes
// - all three bits reset to zero
`ifndef HCSC_CONSTS_SVH
`define HCSC_CONSTS_SVH
`define HCSC_STATUS_CMD_ADDR 8'hff
`define HCSC_BIT_SLEEP 2
`define HCSC_BIT_SRST 1
`define HCSC_BIT_ATTACH 0
`define HCSC_RESET_VAL 3'h0
`endif

// ### core/hcsc_pkg.sv
// types for the hub status/command register block
// assumes the constants header is included by users
package hcsc_pkg;
   typedef enum logic [1:0] {
      HCSC_RUN = 2'b00,
      HCSC_WAIT_ACK = 2'b01,
      HCSC_ASLEEP = 2'b10
   } hcsc_sleep_t;
endpackage

// ### core/hcsc_sync.sv
// three-flop synchroniser for a pin input
// assumes one clock; a change counts when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module hcsc_sync (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_pin,
   output logic o_level
);
   logic [2:0] sh_q;
   logic lvl_q;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sh_q <= 3'h0;
         lvl_q <= 1'b0;
      end else begin
         sh_q <= {sh_q[1:0], i_pin};
         if (sh_q[1] == sh_q[2]) begin
            lvl_q <= sh_q[2];
         end
      end
   end
   assign o_level = lvl_q;
endmodule
`default_nettype wire

// ### core/hcsc_top.sv
// hub status/command register with sleep, soft reset and attach control
// assumes a configuration write/read port driven by the serial slave, with an ack-done pulse
`include "hcsc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module hcsc_top
   import hcsc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_modify_ok,
   input wire logic i_ack_done,
   output logic [7:0] o_rdata,
   output logic o_serial_port_sleep,
   output logic o_serial_active,
   output logic o_cfg_soft_reset,
   output logic o_cfg_write_protect,
   output logic o_cfg_wr_en,
   output logic o_upstream_attach
);
   typedef struct packed {
      hcsc_sleep_t sleep_st;
      logic attach;
      logic srst;
      logic [7:0] rdata;
      logic wr_en;
      logic slp;
      logic act;
   } hcsc_state_t;

   hcsc_state_t st_q, st_d;
   logic ack_lvl;
   logic ack_prev_q;
   logic ack_pulse;

   ////////////////////////////////////////////////////////////////////////
   // the ack strobe comes from the serial engine pad timing, so sync it
   hcsc_sync u_ack_sync (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_pin(i_ack_done),
      .o_level(ack_lvl)
   );

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ack_prev_q <= 1'b0;
      end else begin
         ack_prev_q <= ack_lvl;
      end
   end
   assign ack_pulse = ack_lvl & ~ack_prev_q;

   ////////////////////////////////////////////////////////////////////////
   logic hit;
   logic asleep;
   always_comb begin
      st_d = st_q;
      asleep = (st_q.sleep_st == HCSC_ASLEEP);
      hit = (i_addr == `HCSC_STATUS_CMD_ADDR);
      st_d.srst = 1'b0;
      st_d.wr_en = 1'b0;
      if (st_q.sleep_st == HCSC_WAIT_ACK && ack_pulse) begin
         st_d.sleep_st = HCSC_ASLEEP;
      end
      if (i_wr && !asleep && !st_q.srst) begin
         if (hit) begin
            if (i_wdata[`HCSC_BIT_SLEEP] && st_q.sleep_st == HCSC_RUN) begin
               st_d.sleep_st = HCSC_WAIT_ACK;
            end
            if (i_wdata[`HCSC_BIT_ATTACH]) begin
               st_d.attach = 1'b1;
            end
            st_d.srst = i_wdata[`HCSC_BIT_SRST];
         end else begin
            st_d.wr_en = !st_q.attach || i_modify_ok;
         end
      end
      if (i_rd && hit) begin
         st_d.rdata = {5'h00, st_q.sleep_st != HCSC_RUN, st_q.srst, st_q.attach};
      end
      if (st_q.srst) begin
         st_d.rdata = 8'h00;
      end
      // registered copies so the pins come straight from flops
      st_d.slp = (st_d.sleep_st == HCSC_ASLEEP);
      st_d.act = (st_d.sleep_st != HCSC_ASLEEP);
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q <= '{sleep_st: HCSC_RUN, attach: 1'b0, srst: 1'b0, rdata: 8'h00, wr_en: 1'b0,
                   slp: 1'b0, act: 1'b1};
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign o_rdata = st_q.rdata;
   assign o_serial_port_sleep = st_q.slp;
   assign o_serial_active = st_q.act;
   assign o_cfg_soft_reset = st_q.srst;
   assign o_cfg_write_protect = st_q.attach;
   assign o_cfg_wr_en = st_q.wr_en;
   assign o_upstream_attach = st_q.attach;
endmodule
`default_nettype wire

// ### tb/hcsc_properties.sv
// checker on the register ports
`timescale 1ns/1ps
`default_nettype none
module hcsc_properties(
   input wire logic i_clk,i_rstn,i_wr,i_rd,i_modify_ok,
   input wire logic [7:0] i_addr,i_wdata,o_rdata,
   input wire logic o_serial_port_sleep,o_serial_active,o_cfg_soft_reset,
   input wire logic o_cfg_write_protect,o_cfg_wr_en,o_upstream_attach);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   wire logic wok=i_wr&&i_addr==8'hff&&o_serial_active&&!o_cfg_soft_reset;
   sequence s_sr; o_cfg_soft_reset ##1 !o_cfg_soft_reset; endsequence
   property p_at; wok&&i_wdata[0]|=>o_upstream_attach; endproperty
   a_at: assert property(p_at) else $error("attach");
   property p_sr; wok&&i_wdata[1]|=>s_sr; endproperty
   a_sr: assert property(p_sr) else $error("soft reset");
   property p_h; o_upstream_attach|=>o_upstream_attach; endproperty
   a_h: assert property(p_h) else $error("attach lost");
   property p_n; o_serial_port_sleep|=>o_serial_port_sleep; endproperty
   a_n: assert property(p_n) else $error("sleep lost");
   property p_a; o_serial_active!=o_serial_port_sleep; endproperty
   a_a: assert property(p_a) else $error("active");
   property p_w; o_cfg_write_protect==o_upstream_attach; endproperty
   a_w: assert property(p_w) else $error("protect");
   property p_p; i_wr&&!i_modify_ok&&o_cfg_write_protect&&i_addr!=8'hff|=>!o_cfg_wr_en; endproperty
   a_p: assert property(p_p) else $error("write leak");
   property p_r; i_rd&&i_addr==8'hff|=>o_rdata[7:3]==5'h00; endproperty
   a_r: assert property(p_r) else $error("reserved");
endmodule
bind hcsc_top hcsc_properties hcsc_properties_i(.*);
`default_nettype wire

// ### tb/hcsc_host.sv
// serial engine stand-in: ack stands four cycles after a write
// a one-cycle ack would be lost in the design's three-flop filter
`timescale 1ns/1ps
`default_nettype none
module hcsc_host(input wire logic i_clk,i_wr,output logic o_ack);
   logic [2:0] cnt=3'h0;
   always @(posedge i_clk) begin
      if(i_wr) cnt<=3'h4;
      else if(cnt!=3'h0) cnt<=cnt-3'h1;
   end
   assign o_ack=(cnt!=3'h0);
endmodule
`default_nettype wire

// ### tb/hcsc_bench.sv
// bench: register port tasks, partner gives ack
`timescale 1ns/1ps
`default_nettype none
module hcsc_bench;
   logic i_clk=0,i_rstn=0,i_wr=0,i_rd=0,i_modify_ok=0;
   logic [7:0] i_addr=8'h00,i_wdata=8'h00;
   wire logic [7:0] o_rdata;
   wire logic o_serial_port_sleep,o_serial_active,o_cfg_soft_reset,o_cfg_write_protect;
   wire logic o_cfg_wr_en,o_upstream_attach,i_ack_done;
   int fails=0,samples_checked=0;
   hcsc_top hcsc_top_i(.*);
   hcsc_host hcsc_host_i(.i_clk,.i_wr,.o_ack(i_ack_done));
   task chk(input logic [7:0] g,e);
      samples_checked++;
      if(g!==e) begin
         fails++;
         $display("MISMATCH %0t got %h want %h",$time,g,e);
      end
   endtask
   task acc(input logic w,input logic [7:0] a,d,input logic m);
      @(posedge i_clk);
      i_wr<=w;
      i_rd<=!w;
      i_addr<=a;
      i_wdata<=d;
      i_modify_ok<=m;
      @(posedge i_clk);
      i_wr<=0;
      i_rd<=0;
      #1;
   endtask
   task end_sim;
      $display("checked %0d fails %0d",samples_checked,fails);
      if(fails==0&&samples_checked>0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial forever #2 i_clk=~i_clk;
   initial begin
      #9000 fails++;
      end_sim;
   end
   initial begin
      repeat(20) @(posedge i_clk);
      i_rstn<=1;
      acc(0,8'hff,8'h00,0); chk(o_rdata,8'h00);
      acc(1,8'h10,8'h00,0); chk(o_cfg_wr_en,8'h01);
      acc(1,8'hff,8'h02,0); chk(o_cfg_soft_reset,8'h01);
      #4 chk(o_cfg_soft_reset,8'h00);
      $display("test one done");
      acc(1,8'h20,8'h00,0); chk(o_cfg_wr_en,8'h01);
      acc(1,8'hff,8'h01,0); chk(o_upstream_attach,8'h01);
      acc(1,8'hff,8'h00,0); chk(o_upstream_attach,8'h01);
      acc(1,8'h10,8'h00,0); chk(o_cfg_wr_en,8'h00);
      acc(1,8'h10,8'h00,1); chk(o_cfg_wr_en,8'h01);
      repeat(10) @(posedge i_clk);
      acc(1,8'hff,8'h04,0); #40 chk(o_serial_active,8'h00);
      chk(o_serial_port_sleep,8'h01);
      $display("test two done");
      @(posedge i_clk) i_rstn<=0;
      #1 chk(o_upstream_attach,8'h00);
      chk(o_serial_port_sleep,8'h00);
      chk(o_serial_active,8'h01);
      @(posedge i_clk) i_rstn<=1;
      acc(1,8'h10,8'h00,0); chk(o_cfg_wr_en,8'h01);
      $display("test three done");
      end_sim;
   end
endmodule
`default_nettype wire
